//--- sadc_top.sv
// Converter sequencer top: register port, analog front-end control, completion pulse
// ----------------------------------------------------------------
// Overview of operation
// - Starts idle in channel select; only software setting run bit starts converting.
// - Samples selected channel, then holds it until conversion finishes.
// - Conversion sets bit 7, half tap; keeps bit if input not below tap.
// - Each lower bit trial-set, tap from decided bits, kept if input not below.
// - After eight decisions result register loads and completion pulse fires together.
// - Result equals integer of Vin over Vref times 256 plus half.
// - Each completed conversion automatically starts another while run bit set.
// - Repetition continues until software clears run bit, mode bit 7.
// - Mode or channel write during conversion aborts it; restart if run set.
// - Mode write with run clear halts conversion immediately, no completion.
// - Result read coinciding with result update returns old value; update follows.
// - Mode or channel write at conversion end drops result and completion pulse.
// - Standby stops the converter; clearing run beforehand saves current.
// - Reset leaves result register contents undefined, not cleared.
// - Mode register: run bit 7, time field bits 5..3, others zero, reset zero.
// - Time codes 000,001,010,100 give 144,120,96,72 clocks; others prohibited.
// - Channel register low three bits pick inputs 0..6; 111 prohibited; upper zero.
// ----------------------------------------------------------------
`timescale 1ns/100ps
`include "sadc_regs.svh"
module sadc_top (
  input  wire logic                     clk_sys_i,
  input  wire logic                     reset_i,
  input  wire logic [`SADC_ADDR_W-1:0]  addr_i,
  input  wire sadc_pkg::sadc_byte_t     wdata_i,
  input  wire logic                     wr_i,
  input  wire logic                     rd_i,
  output sadc_pkg::sadc_byte_t          rdata_o,
  input  wire logic                     standby_i,
  input  wire logic                     cmp_i,
  output sadc_pkg::sadc_chan_t          chan_sel_o,
  output logic                          hold_o,
  output sadc_pkg::sadc_byte_t          tap_o,
  output logic                          conversion_done_irq_o
);
  import sadc_pkg::*;

  sadc_ctl_if  ctl ();
  sadc_byte_t  converter_mode_reg;
  sadc_chan_t  channel_select_reg;
  sadc_byte_t  conversion_result_reg;
  logic        conversion_done_flag;
  logic        mode_wr;
  logic        chan_wr;
  logic        stat_wr;
  logic        ctl_wr;
  logic        hold_w;
  sadc_byte_t  tap_w;
  logic [2:0]  cmp_sync;
  logic        cmp_stable;
  logic [7:0]  conv_cnt;
  logic        conv_clean;
  logic [7:0]  conv_len;

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  assign mode_wr = wr_i && (addr_i == `SADC_OFS_MODE);
  assign chan_wr = wr_i && (addr_i == `SADC_OFS_CHAN);
  assign stat_wr = wr_i && (addr_i == `SADC_OFS_STATUS);
  assign ctl_wr  = mode_wr || chan_wr;

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      converter_mode_reg <= `SADC_MODE_RESET;
    end else if (mode_wr) begin
      converter_mode_reg <= wdata_i & `SADC_MODE_WMASK;
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      channel_select_reg <= 3'(`SADC_CHAN_RESET);
    end else if (chan_wr && (wdata_i[2:0] != `SADC_CHAN_BAD)) begin
      channel_select_reg <= 3'(wdata_i & `SADC_CHAN_WMASK);
    end
  end

  assign ctl.run       = converter_mode_reg[`SADC_MODE_RUN_BIT];
  assign ctl.time_code = converter_mode_reg[`SADC_MODE_TIME_HI:`SADC_MODE_TIME_LO];
  assign ctl.restart   = ctl_wr;

  // ----------------------------------------------------------------
  // Comparator synchroniser: a change counts once stages two and three agree
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      cmp_sync <= 3'h0;
    end else begin
      cmp_sync <= {cmp_sync[1:0], cmp_i};
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      cmp_stable <= 1'b0;
    end else if (cmp_sync[1] == cmp_sync[2]) begin
      cmp_stable <= cmp_sync[2];
    end
  end

  sadc_engine u_engine (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .standby_i (standby_i),
    .cmp_i     (cmp_stable),
    .ctl       (ctl),
    .hold_o    (hold_w),
    .tap_o     (tap_w)
  );

  // ----------------------------------------------------------------
  // Result and completion
  // ----------------------------------------------------------------
  // No reset on the result: contents stay undefined after reset
  always_ff @(posedge clk_sys_i) begin
    if (ctl.done && !ctl_wr) begin
      conversion_result_reg <= ctl.code;
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      conversion_done_irq_o <= 1'b0;
    end else begin
      conversion_done_irq_o <= ctl.done && !ctl_wr;
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      conversion_done_flag <= 1'b0;
    end else if (ctl.done && !ctl_wr) begin
      conversion_done_flag <= 1'b1;
    end else if (stat_wr && wdata_i[`SADC_STAT_FLAG_BIT]) begin
      conversion_done_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read port: data stands the cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `SADC_OFS_MODE:   rdata_o <= converter_mode_reg;
        `SADC_OFS_CHAN:   rdata_o <= {5'h00, channel_select_reg};
        `SADC_OFS_RESULT: rdata_o <= conversion_result_reg;
        `SADC_OFS_STATUS: rdata_o <= {6'h00, ctl.busy, conversion_done_flag};
        default:          rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Analog front-end controls
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      chan_sel_o <= 3'h0;
      hold_o     <= 1'b0;
      tap_o      <= 8'h00;
    end else begin
      chan_sel_o <= channel_select_reg;
      hold_o     <= hold_w;
      tap_o      <= tap_w;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_irq_one_cycle: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    conversion_done_irq_o |=> !conversion_done_irq_o)
    else $error("completion pulse longer than one cycle");
  chk_irq_sets_flag: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    conversion_done_irq_o |-> conversion_done_flag)
    else $error("completion pulse without flag");
  chk_write_wins: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    ctl_wr |=> !conversion_done_irq_o)
    else $error("completion raised despite register write");
  chk_result_load: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (ctl.done && !ctl_wr) |=> conversion_result_reg == $past(ctl.code))
    else $error("result not loaded at completion");
  chk_stop_idle: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (mode_wr && !wdata_i[`SADC_MODE_RUN_BIT]) |=> ##1 !ctl.busy)
    else $error("stop write did not halt conversion");
  chk_standby_stop: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    standby_i |=> !ctl.busy)
    else $error("converter busy in standby");
  chk_mode_zero_bits: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (converter_mode_reg & ~`SADC_MODE_WMASK) == 8'h00)
    else $error("mode reserved bits set");
  chk_chan_legal: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    channel_select_reg != `SADC_CHAN_BAD)
    else $error("prohibited channel selected");
  chk_idle_no_run: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !ctl.run |=> !ctl.busy)
    else $error("busy without run bit");

  // Cycles between two completions with no register write or stop between
  always_comb begin
    case (ctl.time_code)
      `SADC_TCODE_120: conv_len = `SADC_CYC_120;
      `SADC_TCODE_96:  conv_len = `SADC_CYC_96;
      `SADC_TCODE_72:  conv_len = `SADC_CYC_72;
      default:         conv_len = `SADC_CYC_144;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      conv_cnt <= 8'h00;
    end else if (ctl.done || ctl_wr) begin
      conv_cnt <= 8'h01;
    end else begin
      conv_cnt <= 8'(conv_cnt + 8'h1);
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      conv_clean <= 1'b0;
    end else if (ctl_wr || !ctl.run || standby_i) begin
      conv_clean <= 1'b0;
    end else if (ctl.done) begin
      conv_clean <= 1'b1;
    end
  end

  chk_conv_length: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (ctl.done && conv_clean) |-> conv_cnt == conv_len)
    else $error("conversion length differs from time code");
endmodule

//--- sadc_regs.svh
// Register map, field positions, reset values and timing constants of the converter sequencer
`ifndef SADC_REGS_SVH
`define SADC_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SADC_ADDR_W          4
`define SADC_OFS_MODE        4'h0
`define SADC_OFS_CHAN        4'h4
`define SADC_OFS_RESULT      4'h8
`define SADC_OFS_STATUS      4'hc

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define SADC_MODE_RUN_BIT    7
`define SADC_MODE_TIME_HI    5
`define SADC_MODE_TIME_LO    3
`define SADC_MODE_WMASK      8'hb8
`define SADC_MODE_RESET      8'h00
`define SADC_CHAN_WMASK      8'h07
`define SADC_CHAN_RESET      8'h00
`define SADC_CHAN_BAD        3'h7
`define SADC_STAT_FLAG_BIT   0
`define SADC_STAT_BUSY_BIT   1

// ----------------------------------------------------------------
// Conversion time codes and their periods in main clock cycles
// ----------------------------------------------------------------
`define SADC_TCODE_144       3'h0
`define SADC_TCODE_120       3'h1
`define SADC_TCODE_96        3'h2
`define SADC_TCODE_72        3'h4
`define SADC_CYC_144         8'h90
`define SADC_CYC_120         8'h78
`define SADC_CYC_96          8'h60
`define SADC_CYC_72          8'h48
`define SADC_NBITS           4'h8
`define SADC_NSLOTS          8'h09
`define SADC_MSB_ONEHOT      8'h80
`define SADC_HALF_TAP        8'h80

`endif

//--- sadc_pkg.sv
// Types shared by the converter sequencer modules
package sadc_pkg;
  typedef logic [7:0] sadc_byte_t;
  typedef logic [2:0] sadc_chan_t;
  typedef enum logic [1:0] {SADC_IDLE, SADC_SAMPLE, SADC_STEP} sadc_state_t;
endpackage

//--- sadc_ctl_if.sv
// Control interface between register file and sequencing engine
`timescale 1ns/100ps
interface sadc_ctl_if;
  import sadc_pkg::*;
  logic       run;
  logic [2:0] time_code;
  logic       restart;
  logic       done;
  sadc_byte_t code;
  logic       busy;
  modport regs (output run, time_code, restart, input done, code, busy);
  modport eng  (input run, time_code, restart, output done, code, busy);
endinterface

//--- sadc_engine.sv
// Successive-approximation stepping engine with sample and hold phases
`timescale 1ns/100ps
`include "sadc_regs.svh"
module sadc_engine (
  input  wire logic       clk_sys_i,
  input  wire logic       reset_i,
  input  wire logic       standby_i,
  input  wire logic       cmp_i,
  sadc_ctl_if.eng         ctl,
  output logic            hold_o,
  output sadc_pkg::sadc_byte_t tap_o
);
  import sadc_pkg::*;

  sadc_state_t state;
  sadc_byte_t  approx;
  sadc_byte_t  trial;
  logic [7:0]  slot_len;
  logic [7:0]  slot_cnt;
  logic [7:0]  per_bit;
  logic [7:0]  samp_len;
  logic        slot_end;

  // ----------------------------------------------------------------
  // Slot timing: one sample slot plus eight bit slots per conversion
  // ----------------------------------------------------------------
  always_comb begin
    case (ctl.time_code)
      `SADC_TCODE_120: slot_len = `SADC_CYC_120;
      `SADC_TCODE_96:  slot_len = `SADC_CYC_96;
      `SADC_TCODE_72:  slot_len = `SADC_CYC_72;
      default:         slot_len = `SADC_CYC_144;
    endcase
  end
  // Sample slot takes the remainder so a conversion lasts exactly slot_len
  assign per_bit  = 8'(slot_len / `SADC_NSLOTS);
  assign samp_len = 8'(slot_len - 8'(per_bit * `SADC_NBITS));
  assign slot_end = (slot_cnt == 8'h0);

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state    <= SADC_IDLE;
      approx   <= 8'h00;
      trial    <= 8'h00;
      slot_cnt <= 8'h00;
      ctl.done <= 1'b0;
    end else begin
      ctl.done <= 1'b0;
      if (standby_i || !ctl.run) begin
        state <= SADC_IDLE;
      end else if (ctl.restart || state == SADC_IDLE) begin
        state    <= SADC_SAMPLE;
        slot_cnt <= 8'(samp_len - 8'h1);
      end else if (!slot_end) begin
        slot_cnt <= 8'(slot_cnt - 8'h1);
      end else if (state == SADC_SAMPLE) begin
        state    <= SADC_STEP;
        trial    <= `SADC_MSB_ONEHOT;
        approx   <= `SADC_HALF_TAP;
        slot_cnt <= 8'(per_bit - 8'h1);
      end else begin
        approx   <= next_approx(approx, trial, cmp_i);
        trial    <= trial >> 1;
        if (trial[0]) begin
          ctl.done <= 1'b1;
          state    <= SADC_SAMPLE;
          slot_cnt <= 8'(samp_len - 8'h1);
        end else begin
          slot_cnt <= 8'(per_bit - 8'h1);
        end
      end
    end
  end

  function automatic sadc_byte_t next_approx(sadc_byte_t a, sadc_byte_t t, logic ge);
    sadc_byte_t r;
    r = ge ? a : (a & ~t);
    r = r | (t >> 1);
    return r;
  endfunction

  assign ctl.code = next_approx(approx, trial, cmp_i) & ~(trial >> 1) | 8'h00;
  assign ctl.busy = (state != SADC_IDLE);
  assign hold_o   = (state == SADC_STEP);
  assign tap_o    = approx;
endmodule

//--- sadc_front_model.sv
// Behavioural analog front end: sample-and-hold, tap string and comparator
`timescale 1ns/100ps
module sadc_front_model (
  input  wire logic                 clk_sys_i,
  input  wire logic [6:0][8:0]      vin2_i,
  input  wire sadc_pkg::sadc_chan_t chan_sel_i,
  input  wire logic                 hold_i,
  input  wire sadc_pkg::sadc_byte_t tap_i,
  output logic                      cmp_o
);
  import sadc_pkg::*;
  // ----------------------------------------------------------------
  // Input voltages in half steps of the reference over 256
  // ----------------------------------------------------------------
  logic [8:0] held;

  // Tracks the selected input while sampling, frozen while holding
  always_ff @(posedge clk_sys_i) begin
    if (!hold_i) begin
      held <= (chan_sel_i == 3'h7) ? 9'h000 : vin2_i[chan_sel_i];
    end
  end

  // Taps sit half a step low, so the decided code is rounded
  assign cmp_o = ({1'b0, held} + 10'h001) >= {1'b0, tap_i, 1'b0};
endmodule

//--- sadc_top_bench.sv
// Self-checking bench of the converter sequencer against a behavioural reference
`timescale 1ns/100ps
`include "sadc_regs.svh"
module sadc_top_bench;
  import sadc_pkg::*;
  // ----------------------------------------------------------------
  // Signals and reference state
  // ----------------------------------------------------------------
  logic                    clk_sys_i;
  logic                    reset_i;
  logic                    wr_i;
  logic                    rd_i;
  logic                    standby_i;
  logic                    cmp;
  logic                    hold_o;
  logic                    irq;
  logic [`SADC_ADDR_W-1:0] addr_i;
  sadc_byte_t              wdata_i;
  sadc_byte_t              rdata_o;
  sadc_byte_t              tap_o;
  sadc_byte_t              rv;
  sadc_byte_t              ch;
  sadc_byte_t              mode;
  sadc_byte_t              oldv;
  sadc_chan_t              chan_sel_o;
  logic [6:0][8:0]         vin2;
  logic [31:0]             seed;
  int                      fails = 0;
  int                      tests_run = 0;
  int                      cyc = 0;
  int                      irq_n = 0;
  int                      irq_at = 0;
  int                      period = 0;
  int                      slot;
  int                      n0;
  int                      codes[4] = '{0, 1, 2, 4};
  int                      nclk[4] = '{144, 120, 96, 72};

  sadc_top i_dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .standby_i(standby_i), .cmp_i(cmp), .chan_sel_o(chan_sel_o),
    .hold_o(hold_o), .tap_o(tap_o), .conversion_done_irq_o(irq));
  sadc_front_model i_front (.clk_sys_i(clk_sys_i), .vin2_i(vin2), .chan_sel_i(chan_sel_o), .hold_i(hold_o),
    .tap_i(tap_o), .cmp_o(cmp));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic sadc_byte_t exp_code(input int v);
    return ((v + 1) / 2 > 255) ? 8'hff : 8'((v + 1) / 2);
  endfunction

  task automatic end_of_test();
    if (fails == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input string name, input sadc_byte_t seen, input sadc_byte_t exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic bus_wr(input logic [3:0] a, input sadc_byte_t d);
    @(posedge clk_sys_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    wr_i    <= 1'b0;
  endtask

  task automatic bus_rd(input logic [3:0] a, output sadc_byte_t d);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    rd_i   <= 1'b0;
    #1 d = rdata_o;
  endtask

  // Returns just after the edge at which the pulse was seen
  task automatic wait_irq(input int lim);
    int m;
    m = irq_n;
    for (int i = 0; i < lim && irq_n == m; i++) begin
      @(posedge clk_sys_i);
      #1;
    end
    check("irq arrival", 8'(irq_n > m), 8'h01);
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog and pulse monitor
  // ----------------------------------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  initial begin
    #1000000;
    fails++;
    end_of_test();
  end

  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (irq === 1'b1) begin
      irq_n  <= irq_n + 1;
      period <= cyc - irq_at;
      irq_at <= cyc;
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    reset_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = '0;
    wdata_i = 8'h00;
    standby_i = 1'b0;
    vin2 = '0;
    seed = 32'h5;
    repeat (8) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    bus_rd(`SADC_OFS_MODE, rv);
    check("mode reset", rv, `SADC_MODE_RESET);
    bus_rd(`SADC_OFS_CHAN, rv);
    check("chan reset", rv, `SADC_CHAN_RESET);
    bus_rd(4'h2, rv);
    check("unmapped read", rv, 8'h00);
    bus_wr(`SADC_OFS_MODE, 8'h47);
    bus_rd(`SADC_OFS_MODE, rv);
    check("mode fixed zeros", rv, 8'h00);
    repeat (200) @(posedge clk_sys_i);
    check("no start without run", 8'(irq_n), 8'h00);
    check("idle sampling", 8'(hold_o), 8'h00);
    for (int k = 0; k < 4; k++) begin
      for (int c = 0; c < 7; c++) begin
        seed = xs(seed);
        vin2[c] = seed[8:0];
      end
      seed = xs(seed);
      ch = 8'(seed % 7);
      mode = 8'h80 | 8'(codes[k] << 3);
      slot = nclk[k];
      bus_wr(`SADC_OFS_CHAN, ch);
      bus_wr(`SADC_OFS_MODE, mode);
      bus_rd(`SADC_OFS_MODE, rv);
      check("mode readback", rv, mode);
      check("channel out", 8'(chan_sel_o), ch);
      wait_irq(2 * slot + 40);
      wait_irq(2 * slot + 40);
      check("conversion period", 8'(period), 8'(slot));
      bus_rd(`SADC_OFS_RESULT, rv);
      check("result code", rv, exp_code(vin2[ch]));
    end
    bus_wr(`SADC_OFS_CHAN, 8'h07);
    bus_rd(`SADC_OFS_CHAN, rv);
    check("chan 111 ignored", rv, ch);
    wait_irq(200);
    bus_wr(`SADC_OFS_MODE, mode);
    bus_rd(`SADC_OFS_STATUS, rv);
    check("flag kept on mode write", rv & 8'h01, 8'h01);
    bus_wr(`SADC_OFS_STATUS, 8'h01);
    bus_rd(`SADC_OFS_STATUS, rv);
    check("flag cleared", rv & 8'h01, 8'h00);
    wait_irq(200);
    oldv = exp_code(vin2[ch]);
    vin2[ch] = vin2[ch] ^ 9'h100;
    repeat (slot - 3) @(posedge clk_sys_i);
    bus_rd(`SADC_OFS_RESULT, rv);
    check("read at update old", rv, oldv);
    bus_rd(`SADC_OFS_RESULT, rv);
    check("read after update", rv, exp_code(vin2[ch]));
    oldv = rv;
    wait_irq(200);
    n0 = irq_n;
    vin2[ch] = vin2[ch] ^ 9'h100;
    repeat (slot - 3) @(posedge clk_sys_i);
    bus_wr(`SADC_OFS_CHAN, ch);
    repeat (slot - 4) @(posedge clk_sys_i);
    check("no pulse on conflict", 8'(irq_n - n0), 8'h00);
    bus_rd(`SADC_OFS_RESULT, rv);
    check("result kept on conflict", rv, oldv);
    wait_irq(200);
    bus_rd(`SADC_OFS_RESULT, rv);
    check("result after restart", rv, exp_code(vin2[ch]));
    repeat (20) @(posedge clk_sys_i);
    bus_wr(`SADC_OFS_MODE, mode & 8'h7f);
    n0 = irq_n;
    repeat (300) @(posedge clk_sys_i);
    check("halt on run clear", 8'(irq_n - n0), 8'h00);
    check("hold released", 8'(hold_o), 8'h00);
    bus_wr(`SADC_OFS_MODE, mode);
    wait_irq(300);
    @(posedge clk_sys_i);
    standby_i <= 1'b1;
    n0 = irq_n;
    repeat (300) @(posedge clk_sys_i);
    check("standby stops", 8'(irq_n - n0), 8'h00);
    standby_i <= 1'b0;
    wait_irq(300);
    end_of_test();
  end
endmodule
